// *** inc/mie_pkg.sv ***
// Shared constants for the instruction execute block: register map, field
// positions, opcode codes and arithmetic constants.
// Assumes a 32-bit classic Wishbone slave port and a 192-byte data memory.
package mie_pkg;

  localparam int DATA_W  = 8;
  localparam int PC_W    = 12;
  localparam int MADDR_W = 8;
  localparam int OPC_W   = 5;
  localparam int MEM_DEPTH = 192;

  // ----------------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] REG_INSTR    = 8'h00;
  localparam logic [7:0] REG_ACC      = 8'h04;
  localparam logic [7:0] REG_STATUS   = 8'h08;
  localparam logic [7:0] REG_PC       = 8'h0C;
  localparam logic [7:0] REG_MEM_ADDR = 8'h10;
  localparam logic [7:0] REG_MEM_DATA = 8'h14;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int INSTR_OPC_LSB  = 16;
  localparam int INSTR_ADDR_LSB = 8;
  localparam int INSTR_IMM_LSB  = 0;
  localparam int INSTR_W        = 21;

  localparam int ST_CARRY    = 0;
  localparam int ST_AUX      = 1;
  localparam int ST_ZERO     = 2;
  localparam int ST_OVF      = 3;
  localparam int ST_PWRDN    = 4;
  localparam int ST_TIMEOUT  = 5;
  localparam int ST_BUSY     = 6;
  localparam int ST_PRE1     = 7;
  localparam int ST_PRE2     = 8;
  localparam int ST_HALTED   = 9;
  localparam int ST_IRQ_EN   = 10;

  // ----------------------------------------------------------------------
  // Arithmetic constants and reset values
  // ----------------------------------------------------------------------
  localparam logic [3:0]  BCD_LIMIT = 4'h9;
  localparam logic [3:0]  BCD_ADJ   = 4'h6;
  localparam logic [PC_W-1:0]   PC_STEP   = 12'h001;
  localparam logic [PC_W-1:0]   PC_RESET  = 12'h000;
  localparam logic [DATA_W-1:0] BYTE_ONE  = 8'h01;
  localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;

  typedef enum logic [OPC_W-1:0] {
    OP_NOP            = 5'h00,
    OP_PRECLEAR_FIRST = 5'h01,
    OP_PRECLEAR_SECOND= 5'h02,
    OP_COMPLEMENT_MEM = 5'h03,
    OP_COMPLEMENT_ACC = 5'h04,
    OP_DECIMAL_ADJUST = 5'h05,
    OP_DEC_MEM        = 5'h06,
    OP_DEC_ACC        = 5'h07,
    OP_INC_MEM        = 5'h08,
    OP_INC_ACC        = 5'h09,
    OP_HALT           = 5'h0A,
    OP_JUMP           = 5'h0B,
    OP_MOV_IMM        = 5'h0C,
    OP_MOV_TO_ACC     = 5'h0D,
    OP_MOV_TO_MEM     = 5'h0E,
    OP_OR_ACC_MEM     = 5'h0F,
    OP_OR_ACC_IMM     = 5'h10,
    OP_OR_TO_MEM      = 5'h11,
    OP_RETURN         = 5'h12,
    OP_RETURN_IMM     = 5'h13,
    OP_INT_RETURN     = 5'h14,
    OP_ROT_MEM        = 5'h15,
    OP_ROT_ACC        = 5'h16
  } mie_opcode_type;

  typedef enum logic [3:0] {
    S_IDLE  = 4'b0001,
    S_FETCH = 4'b0010,
    S_EXEC  = 4'b0100,
    S_RET2  = 4'b1000
  } mie_state_type;

endpackage : mie_pkg

// *** rtl/mie_data_mem.sv ***
// Single-port data memory with registered read data.
// Assumes one clock; addresses at or above the depth read as zero and
// ignore writes.
`timescale 1ns/1ns
module mie_data_mem (
  input  wire logic                        clk,
  input  wire logic [mie_pkg::MADDR_W-1:0] addr,
  input  wire logic                        wr_en,
  input  wire logic [mie_pkg::DATA_W-1:0]  wr_data,
  output      logic [mie_pkg::DATA_W-1:0]  rd_data
);

  logic [mie_pkg::DATA_W-1:0] mem [mie_pkg::MEM_DEPTH];
  logic                       in_range;

  assign in_range = (32'(addr) < mie_pkg::MEM_DEPTH);

  always_ff @(posedge clk) begin
    if (wr_en && in_range) begin
      mem[addr] <= wr_data;
    end
  end

  // Out-of-range reads return zero so no X leaks from unbacked addresses.
  always_ff @(posedge clk) begin
    if (in_range) begin
      rd_data <= mem[addr];
    end else begin
      rd_data <= mie_pkg::BYTE_ZERO;
    end
  end

endmodule : mie_data_mem

// *** rtl/mie_exec.sv ***
// Execute unit for a subset of an 8-bit controller instruction set.
// Assumes a classic Wishbone master on clk, a stack unit that presents its
// top entry on stack_top, and watchdog and clock units that obey the pulses.
//
// Our own choices: the register addresses and the Wishbone slave port.
`timescale 1ns/1ns

// Notes on behaviour
// RULE_01 - Both preclears executed: clear watchdog, timeout and powerdown flags.
// RULE_02 - Only one preclear executed: just remember it, touch nothing else.
// RULE_03 - Complement inverts byte, to memory or accumulator, zero flag only.
// RULE_04 - Adjust low nibble by 6 if over 9 or aux carry; inner carry.
// RULE_05 - Adjust high nibble with inner carry, set carry, result to memory.
// RULE_06 - Decrement byte by one, to memory or accumulator, zero flag only.
// RULE_07 - Increment byte by one, to memory or accumulator, zero flag only.
// RULE_08 - Halt: pc plus one, stop, clock off, powerdown set, timeout clear.
// RULE_09 - Halt also clears watchdog counter and prescaler.
// RULE_10 - Jump loads pc from instruction, no flag changes.
// RULE_11 - Move immediate loads accumulator, no flag changes.
// RULE_12 - Memory to accumulator move, no flag changes.
// RULE_13 - Accumulator to memory move, no flag changes.
// RULE_14 - No operation only advances pc by one.
// RULE_15 - Accumulator OR with memory or immediate, zero flag only.
// RULE_16 - OR into memory with accumulator, zero flag only.
// RULE_17 - Return reloads pc from stack in two cycles, no flags.
// RULE_18 - Return with constant also loads accumulator with immediate.
// RULE_19 - Interrupt return reloads pc and sets global interrupt enable.
// RULE_20 - Rotate memory left, bit 7 into bit 0, no flags.
// RULE_21 - Rotate left into accumulator, memory unchanged.
// RULE_22 - Zero flag set when result is zero, cleared otherwise.
module mie_exec (
  input  wire logic                     clk,
  input  wire logic                     srst,
  input  wire logic                     cyc_i,
  input  wire logic                     stb_i,
  input  wire logic                     we_i,
  input  wire logic [7:0]               adr_i,
  input  wire logic [3:0]               sel_i,
  input  wire logic [31:0]              dat_i,
  output      logic [31:0]              dat_o,
  output      logic                     ack_o,
  input  wire logic [mie_pkg::PC_W-1:0] stack_top,
  output      logic                     stack_pop,
  input  wire logic                     wdt_timeout,
  input  wire logic                     wake,
  input  wire logic                     irq_taken,
  output      logic                     wdt_clear,
  output      logic                     wdt_prescaler_clear,
  output      logic                     sys_clk_off,
  output      logic                     timeout_flag,
  output      logic                     powerdown_flag,
  output      logic                     global_irq_enable
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  localparam int DW = mie_pkg::DATA_W;

  mie_pkg::mie_state_type       state_q;
  mie_pkg::mie_opcode_type      opc_q;
  logic [mie_pkg::INSTR_W-1:0]  instr_q;
  logic [mie_pkg::MADDR_W-1:0]  op_addr_q;
  logic [DW-1:0]                imm_q;
  logic [DW-1:0]                acc_q;
  logic [mie_pkg::PC_W-1:0]     pc_q;
  logic [mie_pkg::MADDR_W-1:0]  mem_addr_q;
  logic                         carry_q;
  logic                         aux_carry_flag_q;
  logic                         zero_q;
  logic                         overflow_flag_q;
  logic                         pre1_q;
  logic                         pre2_q;
  logic                         halted_q;
  logic                         settle_q;
  logic                         ack_q;
  logic [31:0]                  dat_q;

  logic                         bus_req;
  logic                         bus_wr;
  logic                         stall;
  logic                         exec_now;
  logic                         instr_go;
  logic [DW-1:0]                mem_rd;
  logic [DW-1:0]                result;
  logic                         res_to_mem;
  logic                         res_to_acc;
  logic                         res_sets_zero;
  logic [DW:0]                  bcd_out;
  logic [mie_pkg::MADDR_W-1:0]  mem_addr_mux;
  logic                         mem_we;
  logic [DW-1:0]                mem_wdata;
  logic [31:0]                  status_word;
  logic                         preclear_pair;
  logic                         halt_now;

  // ----------------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------------
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  sel);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge_bytes

  function automatic logic hit(input logic [7:0] adr,
                               input logic [7:0] off);
    return adr[7:2] == off[7:2];
  endfunction : hit

  function automatic logic is_zero(input logic [DW-1:0] v);
    return v == mie_pkg::BYTE_ZERO; // see RULE_22
  endfunction : is_zero

  // Decimal adjust of the accumulator; returns {carry, adjusted byte}.
  function automatic logic [DW:0] bcd_adjust(input logic [DW-1:0] a,
                                             input logic          ac,
                                             input logic          c);
    logic [3:0] lo;
    logic       ac1;
    logic [4:0] hi;
    logic       c_out;
    lo    = a[3:0];
    ac1   = 1'b0;
    hi    = {1'b0, a[7:4]};
    c_out = c;
    if ((a[3:0] > mie_pkg::BCD_LIMIT) || ac) begin
      lo  = a[3:0] + mie_pkg::BCD_ADJ; // see RULE_04
      ac1 = ~ac; // see RULE_04
    end
    hi = hi + {4'h0, ac1};
    if ((hi > {1'b0, mie_pkg::BCD_LIMIT}) || c) begin
      hi    = hi + {1'b0, mie_pkg::BCD_ADJ}; // see RULE_05
      c_out = 1'b1; // see RULE_05
    end
    return {c_out, hi[3:0], lo};
  endfunction : bcd_adjust

  // ----------------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------------
  // Memory window accesses wait while an instruction owns the memory port,
  // plus one settle cycle so the read data reflect the bus address again.
  assign bus_req = cyc_i && stb_i;
  assign stall   = hit(adr_i, mie_pkg::REG_MEM_DATA) &&
                   ((state_q != mie_pkg::S_IDLE) || settle_q);
  assign bus_wr  = ack_q && bus_req && we_i;
  assign ack_o   = ack_q;
  assign dat_o   = dat_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= bus_req && !ack_q && !stall;
    end
  end

  assign status_word = {21'h0, global_irq_enable, halted_q, pre2_q,
                        pre1_q, (state_q != mie_pkg::S_IDLE),
                        timeout_flag, powerdown_flag, overflow_flag_q,
                        zero_q, aux_carry_flag_q, carry_q};

  always_ff @(posedge clk) begin
    if (srst) begin
      dat_q <= 32'h00000000;
    end else if (bus_req && !ack_q && !stall) begin
      if (hit(adr_i, mie_pkg::REG_INSTR)) begin
        dat_q <= 32'(instr_q);
      end else if (hit(adr_i, mie_pkg::REG_ACC)) begin
        dat_q <= 32'(acc_q);
      end else if (hit(adr_i, mie_pkg::REG_STATUS)) begin
        dat_q <= status_word;
      end else if (hit(adr_i, mie_pkg::REG_PC)) begin
        dat_q <= 32'(pc_q);
      end else if (hit(adr_i, mie_pkg::REG_MEM_ADDR)) begin
        dat_q <= 32'(mem_addr_q);
      end else if (hit(adr_i, mie_pkg::REG_MEM_DATA)) begin
        dat_q <= 32'(mem_rd);
      end else begin
        dat_q <= 32'h00000000;
      end
    end
  end

  // Instructions are refused while one is running or the core is halted.
  assign instr_go = bus_wr && hit(adr_i, mie_pkg::REG_INSTR) &&
                    (state_q == mie_pkg::S_IDLE) && !halted_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      instr_q <= '0;
    end else if (instr_go) begin
      instr_q <= mie_pkg::INSTR_W'(merge_bytes(32'(instr_q), dat_i, sel_i));
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      mem_addr_q <= '0;
    end else if (bus_wr && hit(adr_i, mie_pkg::REG_MEM_ADDR) && sel_i[0]) begin
      mem_addr_q <= dat_i[mie_pkg::MADDR_W-1:0];
    end
  end

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      state_q   <= mie_pkg::S_IDLE;
      opc_q     <= mie_pkg::OP_NOP;
      op_addr_q <= '0;
      imm_q     <= '0;
      settle_q  <= 1'b0;
    end else begin
      settle_q <= 1'b0;
      unique case (state_q)
        mie_pkg::S_IDLE: begin
          if (instr_go) begin
            opc_q <= mie_pkg::mie_opcode_type'(
                       dat_i[mie_pkg::INSTR_OPC_LSB +: mie_pkg::OPC_W]);
            op_addr_q <= dat_i[mie_pkg::INSTR_ADDR_LSB +: mie_pkg::MADDR_W];
            imm_q     <= dat_i[mie_pkg::INSTR_IMM_LSB +: DW];
            state_q   <= mie_pkg::S_FETCH;
          end
        end
        mie_pkg::S_FETCH: begin
          state_q <= mie_pkg::S_EXEC;
        end
        mie_pkg::S_EXEC: begin
          if (opc_q == mie_pkg::OP_RETURN || opc_q == mie_pkg::OP_RETURN_IMM
              || opc_q == mie_pkg::OP_INT_RETURN) begin
            state_q <= mie_pkg::S_RET2; // see RULE_17
          end else begin
            state_q  <= mie_pkg::S_IDLE;
            settle_q <= 1'b1;
          end
        end
        mie_pkg::S_RET2: begin
          state_q  <= mie_pkg::S_IDLE;
          settle_q <= 1'b1;
        end
        default: begin
          state_q <= mie_pkg::S_IDLE;
        end
      endcase
    end
  end

  assign exec_now = (state_q == mie_pkg::S_EXEC);

  // ----------------------------------------------------------------------
  // Datapath
  // ----------------------------------------------------------------------
  assign bcd_out = bcd_adjust(acc_q, aux_carry_flag_q, carry_q);

  always_comb begin
    result        = mem_rd;
    res_to_mem    = 1'b0;
    res_to_acc    = 1'b0;
    res_sets_zero = 1'b0;
    unique case (opc_q)
      mie_pkg::OP_COMPLEMENT_MEM, mie_pkg::OP_COMPLEMENT_ACC: begin
        result        = ~mem_rd; // see RULE_03
        res_to_mem    = (opc_q == mie_pkg::OP_COMPLEMENT_MEM);
        res_to_acc    = !res_to_mem;
        res_sets_zero = 1'b1;
      end
      mie_pkg::OP_DEC_MEM, mie_pkg::OP_DEC_ACC: begin
        result        = mem_rd - mie_pkg::BYTE_ONE; // see RULE_06
        res_to_mem    = (opc_q == mie_pkg::OP_DEC_MEM);
        res_to_acc    = !res_to_mem;
        res_sets_zero = 1'b1;
      end
      mie_pkg::OP_INC_MEM, mie_pkg::OP_INC_ACC: begin
        result        = mem_rd + mie_pkg::BYTE_ONE; // see RULE_07
        res_to_mem    = (opc_q == mie_pkg::OP_INC_MEM);
        res_to_acc    = !res_to_mem;
        res_sets_zero = 1'b1;
      end
      mie_pkg::OP_DECIMAL_ADJUST: begin
        result     = bcd_out[DW-1:0]; // see RULE_05
        res_to_mem = 1'b1;
      end
      mie_pkg::OP_MOV_IMM, mie_pkg::OP_RETURN_IMM: begin
        result     = imm_q; // see RULE_11
        res_to_acc = 1'b1;
      end
      mie_pkg::OP_MOV_TO_ACC: begin
        result     = mem_rd; // see RULE_12
        res_to_acc = 1'b1;
      end
      mie_pkg::OP_MOV_TO_MEM: begin
        result     = acc_q; // see RULE_13
        res_to_mem = 1'b1;
      end
      mie_pkg::OP_OR_ACC_MEM, mie_pkg::OP_OR_TO_MEM: begin
        result        = acc_q | mem_rd; // see RULE_15
        res_to_mem    = (opc_q == mie_pkg::OP_OR_TO_MEM); // see RULE_16
        res_to_acc    = !res_to_mem;
        res_sets_zero = 1'b1;
      end
      mie_pkg::OP_OR_ACC_IMM: begin
        result        = acc_q | imm_q; // see RULE_15
        res_to_acc    = 1'b1;
        res_sets_zero = 1'b1;
      end
      mie_pkg::OP_ROT_MEM, mie_pkg::OP_ROT_ACC: begin
        result     = {mem_rd[DW-2:0], mem_rd[DW-1]}; // see RULE_20
        res_to_mem = (opc_q == mie_pkg::OP_ROT_MEM);
        res_to_acc = !res_to_mem; // see RULE_21
      end
      default: ;
    endcase
  end

  // ----------------------------------------------------------------------
  // Data memory
  // ----------------------------------------------------------------------
  assign mem_addr_mux = (state_q == mie_pkg::S_IDLE) ? mem_addr_q
                                                     : op_addr_q;
  assign mem_we    = exec_now ? res_to_mem
                   : (bus_wr && hit(adr_i, mie_pkg::REG_MEM_DATA) &&
                      sel_i[0] && (state_q == mie_pkg::S_IDLE));
  assign mem_wdata = exec_now ? result : dat_i[DW-1:0];

  mie_data_mem u_mem (
    .clk     (clk),
    .addr    (mem_addr_mux),
    .wr_en   (mem_we),
    .wr_data (mem_wdata),
    .rd_data (mem_rd)
  );

  // ----------------------------------------------------------------------
  // Architectural registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      acc_q <= '0;
    end else if (exec_now && res_to_acc) begin
      acc_q <= result; // see RULE_18
    end else if (bus_wr && hit(adr_i, mie_pkg::REG_ACC) && sel_i[0]) begin
      acc_q <= dat_i[DW-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pc_q <= mie_pkg::PC_RESET;
    end else if (exec_now) begin
      unique case (opc_q)
        mie_pkg::OP_JUMP: begin
          pc_q <= {op_addr_q[3:0], imm_q}; // see RULE_10
        end
        mie_pkg::OP_RETURN, mie_pkg::OP_RETURN_IMM,
        mie_pkg::OP_INT_RETURN: begin
          pc_q <= stack_top; // see RULE_17
        end
        default: begin
          pc_q <= pc_q + mie_pkg::PC_STEP; // see RULE_14
        end
      endcase
    end else if (bus_wr && hit(adr_i, mie_pkg::REG_PC)) begin
      pc_q <= mie_pkg::PC_W'(merge_bytes(32'(pc_q), dat_i, sel_i));
    end
  end

  assign stack_pop = exec_now && (opc_q == mie_pkg::OP_RETURN ||
                                  opc_q == mie_pkg::OP_RETURN_IMM ||
                                  opc_q == mie_pkg::OP_INT_RETURN);

  // Arithmetic flags: instructions win over a same-cycle software write.
  always_ff @(posedge clk) begin
    if (srst) begin
      carry_q          <= 1'b0;
      aux_carry_flag_q <= 1'b0;
      zero_q           <= 1'b0;
      overflow_flag_q  <= 1'b0;
    end else if (exec_now) begin
      if (res_sets_zero) begin
        zero_q <= is_zero(result); // see RULE_22
      end
      if (opc_q == mie_pkg::OP_DECIMAL_ADJUST) begin
        carry_q <= bcd_out[DW]; // see RULE_05
      end
    end else if (bus_wr && hit(adr_i, mie_pkg::REG_STATUS) && sel_i[0]) begin
      carry_q          <= dat_i[mie_pkg::ST_CARRY];
      aux_carry_flag_q <= dat_i[mie_pkg::ST_AUX];
      zero_q           <= dat_i[mie_pkg::ST_ZERO];
      overflow_flag_q  <= dat_i[mie_pkg::ST_OVF];
    end
  end

  // ----------------------------------------------------------------------
  // Watchdog pairing, power down and interrupt enable
  // ----------------------------------------------------------------------
  assign preclear_pair = exec_now &&
    ((opc_q == mie_pkg::OP_PRECLEAR_FIRST && pre2_q) ||
     (opc_q == mie_pkg::OP_PRECLEAR_SECOND && pre1_q));

  always_ff @(posedge clk) begin
    if (srst) begin
      pre1_q <= 1'b0;
      pre2_q <= 1'b0;
    end else if (preclear_pair) begin
      pre1_q <= 1'b0; // see RULE_01
      pre2_q <= 1'b0;
    end else if (exec_now && opc_q == mie_pkg::OP_PRECLEAR_FIRST) begin
      pre1_q <= 1'b1; // see RULE_02
    end else if (exec_now && opc_q == mie_pkg::OP_PRECLEAR_SECOND) begin
      pre2_q <= 1'b1; // see RULE_02
    end
  end

  assign halt_now  = exec_now && (opc_q == mie_pkg::OP_HALT);
  assign wdt_clear = preclear_pair || halt_now; // see RULE_01, RULE_09
  assign wdt_prescaler_clear = halt_now; // see RULE_09

  // A watchdog expiry in the clearing cycle is kept: the set wins.
  always_ff @(posedge clk) begin
    if (srst) begin
      timeout_flag <= 1'b0;
    end else if (wdt_timeout) begin
      timeout_flag <= 1'b1;
    end else if (preclear_pair || halt_now) begin
      timeout_flag <= 1'b0; // see RULE_08
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      powerdown_flag <= 1'b0;
    end else if (halt_now) begin
      powerdown_flag <= 1'b1; // see RULE_08
    end else if (preclear_pair) begin
      powerdown_flag <= 1'b0; // see RULE_01
    end
  end

  // The clock stays off until the wake unit signals; a wake in the halt
  // cycle itself is too early and is ignored.
  always_ff @(posedge clk) begin
    if (srst) begin
      halted_q <= 1'b0;
    end else if (halt_now) begin
      halted_q <= 1'b1; // see RULE_08
    end else if (wake) begin
      halted_q <= 1'b0;
    end
  end

  assign sys_clk_off = halted_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      global_irq_enable <= 1'b0;
    end else if (exec_now && opc_q == mie_pkg::OP_INT_RETURN) begin
      global_irq_enable <= 1'b1; // see RULE_19
    end else if (irq_taken) begin
      global_irq_enable <= 1'b0;
    end else if (bus_wr && hit(adr_i, mie_pkg::REG_STATUS) && sel_i[1]) begin
      global_irq_enable <= dat_i[mie_pkg::ST_IRQ_EN];
    end
  end

endmodule : mie_exec

// *** verification/mie_exec_checker.sv ***
// Checker for the execute block: bus handshake and power-state pulses.
// Assumes it is bound to mie_exec and sees only that module's ports.
`timescale 1ns/1ns
module mie_exec_checker (
  input wire logic clk, srst, cyc_i, stb_i, ack_o, stack_pop, wake,
  input wire logic wdt_timeout, irq_taken, wdt_clear, wdt_prescaler_clear,
  input wire logic sys_clk_off, timeout_flag, powerdown_flag,
  input wire logic global_irq_enable
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  ack_once_a: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  ack_cause_a: assert property ($rose(ack_o) |-> $past(cyc_i && stb_i))
    else $error("ack without a request");
  halt_wdt_a: assert property (wdt_prescaler_clear |-> wdt_clear)
    else $error("halt did not clear the watchdog");
  halt_state_a: assert property (
    wdt_prescaler_clear && !wdt_timeout && !wake |=>
    sys_clk_off && powerdown_flag && !timeout_flag)
    else $error("halt state wrong");
  pair_clear_a: assert property (
    wdt_clear && !wdt_timeout && !wdt_prescaler_clear |=>
    !timeout_flag && !powerdown_flag)
    else $error("pair clear left a flag set");
  pd_rise_a: assert property (
    $rose(powerdown_flag) |-> $past(wdt_prescaler_clear))
    else $error("powerdown set without halt");
  pd_fall_a: assert property (
    $fell(powerdown_flag) |-> $past(wdt_clear))
    else $error("powerdown cleared without a full pair");
  pop_once_a: assert property (stack_pop |=> !stack_pop)
    else $error("stack pop longer than one cycle");
  irq_off_a: assert property (irq_taken && !stack_pop && !ack_o |=>
    !global_irq_enable)
    else $error("irq enable not cleared");
  wake_a: assert property (wake && !wdt_prescaler_clear |=> !sys_clk_off)
    else $error("wake did not restart the clock");
endmodule : mie_exec_checker

bind mie_exec mie_exec_checker chk_u (.*);

// *** verification/mie_exec_bench.sv ***
// Bench for the execute block: random instructions over Wishbone, checked
// against a behavioural model. Assumes mie_pkg and mie_exec are compiled.
`timescale 1ns/1ns
module mie_exec_bench;
  logic clk, srst, cyc_i, stb_i, we_i, wdt_timeout, wake, irq_taken, ack_o;
  logic [7:0] adr_i;
  logic [3:0] sel_i;
  logic [31:0] dat_i, dat_o, q, r;
  logic [11:0] stack_top;
  logic stack_pop, wdt_clear, wdt_prescaler_clear, sys_clk_off;
  logic timeout_flag, powerdown_flag, global_irq_enable;
  int n_errors, compares, op, a, x, m, acc, pc, c, ac, z, ov, pd, to;
  int p1, p2, hlt, ie, zr, lo, hi, k, x2;
  mie_exec dut_u (.*);
  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end
  task automatic conclude;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude
  task automatic chk(string s, logic [31:0] e, logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s exp %0h got %0h", s, e, g);
    end
  endtask : chk
  // One classic cycle; the bound stops a slave that never answers.
  task automatic wb(logic w, logic [7:0] ad, logic [3:0] se, logic [31:0] d);
    int n;
    n = 0;
    {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {2'h3, w, ad, se, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack_o !== 1'h1 && n < 40);
    if (ack_o !== 1'h1) begin
      n_errors++;
      conclude();
    end
    q = dat_o;
    {cyc_i, stb_i} <= 2'h0;
    @(posedge clk);
  endtask : wb
  function automatic logic [31:0] st();
    return 32'(ie * 1024 + hlt * 512 + p2 * 256 + p1 * 128 + to * 32 +
               pd * 16 + ov * 8 + z * 4 + ac * 2 + c);
  endfunction : st
  initial begin
    {srst, cyc_i, stb_i, we_i, wdt_timeout, wake, irq_taken} = 7'h40;
    {adr_i, sel_i, dat_i, stack_top} = 56'h0;
    void'($urandom(32'hAFBC8274));
    repeat (12) @(posedge clk);
    srst <= 1'h0;
    @(posedge clk);
    wb(1'h0, 8'h08, 4'hF, 32'h0);
    chk("status reset", 32'h0, q);
    wb(1'h1, 8'h20, 4'hF, 32'hFF);
    wb(1'h0, 8'h20, 4'hF, 32'h0);
    chk("unmapped", 32'h0, q);
    for (k = 0; k < 400; k++) begin
      op = $urandom % 24;
      a = $urandom % 192;
      x = $urandom % 256;
      m = $urandom % 256;
      acc = $urandom % 256;
      r = $urandom;
      c = r[0];
      ac = r[1];
      z = r[2];
      ov = r[3];
      ie = r[4];
      pc = r[19:8];
      stack_top <= r[31:20];
      wb(1'h1, 8'h04, 4'hF, 32'(acc));
      wb(1'h1, 8'h08, 4'h3, st());
      wb(1'h1, 8'h0C, 4'hF, 32'(pc));
      wb(1'h1, 8'h10, 4'hF, 32'(a));
      wb(1'h1, 8'h14, 4'hF, 32'(m));
      x2 = $urandom % 8;
      {wake, irq_taken, wdt_timeout} <= 3'(x2);
      @(posedge clk);
      {wake, irq_taken, wdt_timeout} <= 3'h0;
      if (x2[0]) to = 1;
      if (x2[1]) ie = 0;
      if (x2[2]) hlt = 0;
      wb(1'h1, 8'h00, 4'hF, {11'h0, 5'(op), 8'(a), 8'(x)});
      q = 32'h40;
      for (int n = 0; n < 20 && q[6]; n++) wb(1'h0, 8'h08, 4'hF, 32'h0);
      if (q[6]) begin
        n_errors++;
        conclude();
      end
      zr = -1;
      if (hlt == 0) begin
        pc = (pc + 1) % 4096;
        case (op)
          1: if (p2) {p2, to, pd} = 0; else p1 = 1;
          2: if (p1) {p1, to, pd} = 0; else p2 = 1;
          3: begin m = 255 - m; zr = m; end
          4: begin acc = 255 - m; zr = acc; end
          5: begin
            lo = acc % 16;
            hi = acc / 16;
            if (lo > 9 || ac) begin lo = (lo + 6) % 16; hi += 1 - ac; end
            if (hi > 9 || c) begin hi += 6; c = 1; end
            m = hi % 16 * 16 + lo;
          end
          6: begin m = (m + 255) % 256; zr = m; end
          7: begin acc = (m + 255) % 256; zr = acc; end
          8: begin m = (m + 1) % 256; zr = m; end
          9: begin acc = (m + 1) % 256; zr = acc; end
          10: {pd, to, hlt} = {32'd1, 32'd0, 32'd1};
          11: pc = a % 16 * 256 + x;
          12: acc = x;
          13: acc = m;
          14: m = acc;
          15: begin acc |= m; zr = acc; end
          16: begin acc |= x; zr = acc; end
          17: begin m |= acc; zr = m; end
          18, 19, 20: begin
            pc = r[31:20];
            if (op == 19) acc = x;
            if (op == 20) ie = 1;
          end
          21: m = m * 2 % 256 + m / 128;
          22: acc = m * 2 % 256 + m / 128;
          default: ;
        endcase
        if (zr >= 0) z = (zr == 0);
      end
      wb(1'h0, 8'h04, 4'hF, 32'h0);
      chk("acc", 32'(acc), q);
      wb(1'h0, 8'h14, 4'hF, 32'h0);
      chk("mem", 32'(m), q);
      wb(1'h0, 8'h08, 4'hF, 32'h0);
      chk("status", st(), q & 32'h7BF);
      wb(1'h0, 8'h0C, 4'hF, 32'h0);
      chk("pc", 32'(pc), q);
      chk("pins", 32'(hlt * 8 + ie * 4 + pd * 2 + to), {28'h0, sys_clk_off,
        global_irq_enable, powerdown_flag, timeout_flag});
      $display("test %0d opcode %0h done", k, op);
    end
    conclude();
  end
endmodule : mie_exec_bench
